// File: core/scd_serial_cfg.sv
// serial command interpreter: port rates, broadcast reply, table download
// Operation
// [RL1] commands start 0x07, replies 0x06, echoing address and command letters
// [RL2] rate write: two bytes port then code, stored and echoed
// [RL3] port 0x00 is RS232, 0xFF RS485; code 0x00 9600, 0xFF 115200
// [RL4] rate read: one port byte; reply port and its rate code
// [RL5] broadcast reply write: one byte, 0x00 off, 0xFF on
// [RL6] broadcast reply setting changes only after the answer is sent
// [RL7] broadcast reply setting restored from nonvolatile store after reset
// [RL8] unprogrammed store gives broadcast reply 0xFF, on
// [RL9] broadcast reply query has no data; reply one byte code
// [RL10] packet fetch with one byte selects packet of active table
// [RL11] valid fetch replies packet number, hyphen, packet content
// [RL12] fetch reply data is at most 32 bytes, length byte says actual
// [RL13] fetch with two bytes: packet number then table number
// [RL14] count query without data replies count of active table
// [RL15] count reply also carries the table number
// [RL16] calibration mode VGA, DVI, DP, HDMI picks table 0 to 3
// [RL17] no calibration mode or empty table gives negative acknowledge
// [RL18] count is table size over 30 bytes, rounded up
// [RL19] bad header or data check gives negative acknowledge, no action
// [RL20] rate change applies only after acknowledge sent at old rate
`timescale 1ns/10ps
`default_nettype none
module scd_serial_cfg
	import scd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_from_485,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic nv_programmed,
	input wire logic [7:0] nv_rate_232,
	input wire logic [7:0] nv_rate_485,
	input wire logic [7:0] nv_bak_code,
	output logic nv_wr,
	output logic [1:0] nv_wr_item,
	output logic [7:0] nv_wr_data,
	output logic [7:0] rate_232,
	output logic [7:0] rate_485,
	output logic bak_on
);
	////////////////////////////////////////////////////////////////////////
	// register file and table memory
	logic [2:0] cal_q, cal_d;
	logic [MEM_AW-1:0] ptr_q, ptr_d;
	logic [SIZE_W-1:0] size_q [TBL_NUM];
	logic [SIZE_W-1:0] size_d [TBL_NUM];
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [7:0] mem_q [1 << MEM_AW];
	logic mem_we;
	logic apb_done;
	logic busy;
	scd_state_t st_q, st_d;
	logic [7:0] rate232_q, rate232_d, rate485_q, rate485_d, bak_q, bak_d;

	assign apb_done = psel & penable & pready_q;
	assign busy = (st_q != S_SYNC);

	// one wait cycle in each access keeps read data a flop output
	always_comb
	begin
		cal_d = cal_q;
		ptr_d = ptr_q;
		size_d = size_q;
		mem_we = 1'b0;
		pready_d = psel & penable & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d = 32'h0000_0000;
		if (psel & penable & ~pready_q)
		begin
			case (paddr)
				REG_CTRL: prdata_d = {29'h0, cal_q};
				REG_TBL_PTR: prdata_d = {20'h0, ptr_q};
				REG_TBL_DATA: prdata_d = {24'h0, mem_q[ptr_q]};
				REG_STATUS: prdata_d = {7'h0, busy, bak_q, rate485_q, rate232_q};
				default:
				begin
					if (paddr[7:4] == REG_SIZE0[7:4] && paddr[1:0] == 2'b00)
						prdata_d = {21'h0, size_q[paddr[3:2]]};
					else
						pslverr_d = 1'b1;
				end
			endcase
		end
		if (apb_done && pwrite)
		begin
			case (paddr)
				REG_CTRL: cal_d = pwdata[2:0];
				REG_TBL_PTR: ptr_d = pwdata[MEM_AW-1:0];
				REG_TBL_DATA:
				begin
					mem_we = 1'b1;
					ptr_d = ptr_q + 1'b1;
				end
				default:
				begin
					if (paddr[7:4] == REG_SIZE0[7:4] && paddr[1:0] == 2'b00)
						size_d[paddr[3:2]] = pwdata[SIZE_W-1:0];
				end
			endcase
		end
		// a read of the data port walks the table too
		if (apb_done && !pwrite && paddr == REG_TBL_DATA)
			ptr_d = ptr_q + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cal_q <= CAL_NONE;
			ptr_q <= '0;
			size_q <= '{default: '0};
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			cal_q <= cal_d;
			ptr_q <= ptr_d;
			size_q <= size_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// table store has no reset; software loads it before use
	always_ff @(posedge pclk)
	begin
		if (mem_we)
			mem_q[ptr_q] <= pwdata[7:0];
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	////////////////////////////////////////////////////////////////////////
	// frame engine
	scd_pend_t pend_q, pend_d;
	logic [7:0] idx_q, idx_d, addr_q, addr_d, len_q, len_d;
	logic [23:0] cmd_q, cmd_d;
	logic [7:0] d0_q, d0_d, d1_q, d1_d;
	logic hok_q, hok_d, dok_q, dok_d, port_q, port_d;
	logic [7:0] ack_q, ack_d, rlen_q, rlen_d, r0_q, r0_d, r1_q, r1_d;
	logic [MEM_AW-1:0] base_q, base_d;
	logic [7:0] tx_data_q, tx_data_d;
	logic tx_valid_q, tx_valid_d;
	logic nv_wr_q, nv_wr_d;
	logic [1:0] nv_item_q, nv_item_d;
	logic [7:0] nv_data_q, nv_data_d;
	logic rs_clr, rs_en, ts_clr, ts_en;
	logic [7:0] rs_chk, ts_chk, ts_din;
	// decode helpers
	logic act_ok, dl_ok, ok, d0_code, d1_code;
	logic [1:0] act_tbl, dl_tbl;
	logic [12:0] dl_size, dl_off, dl_rem, act_size;
	logic [7:0] tot, dj, act_cnt;
	logic [MEM_AW-1:0] rd_addr;

	scd_chk_acc u_rx_sum
	(
		.pclk(pclk),
		.presetn(presetn),
		.clr(rs_clr),
		.en(rs_en),
		.din(rx_data),
		.chk(rs_chk)
	);

	scd_chk_acc u_tx_sum
	(
		.pclk(pclk),
		.presetn(presetn),
		.clr(ts_clr),
		.en(ts_en),
		.din(ts_din),
		.chk(ts_chk)
	);

	// active table and packet arithmetic
	always_comb
	begin
		act_ok = (cal_q != CAL_NONE) && (cal_q <= CAL_HDMI); // RL16
		act_tbl = 2'(cal_q - 3'd1); // RL16
		act_size = {2'b00, size_q[act_tbl]};
		act_cnt = 8'((act_size + PKT_PAYLOAD - 13'd1) / PKT_PAYLOAD); // RL18
		dl_tbl = (len_q == 8'd2) ? d1_q[1:0] : act_tbl; // RL13
		dl_size = {2'b00, size_q[dl_tbl]};
		dl_off = {5'h00, d0_q} * PKT_PAYLOAD;
		dl_rem = dl_size - dl_off;
		dl_ok = (len_q == 8'd2) ? (d1_q < 8'(TBL_NUM)) : act_ok; // RL13
		dl_ok = dl_ok && (dl_off < dl_size);
		ok = hok_q && dok_q; // RL19
		d0_code = (d0_q == CODE_LOW) || (d0_q == CODE_HIGH); // RL3
		d1_code = (d1_q == CODE_LOW) || (d1_q == CODE_HIGH); // RL3
		tot = (rlen_q == 8'd0) ? 8'd7 : rlen_q + 8'd8;
		dj = idx_q - 8'd7;
		rd_addr = base_q + MEM_AW'(dj - 8'd2);
	end

	always_comb
	begin
		st_d = st_q;
		pend_d = pend_q;
		idx_d = idx_q;
		addr_d = addr_q;
		len_d = len_q;
		cmd_d = cmd_q;
		d0_d = d0_q;
		d1_d = d1_q;
		hok_d = hok_q;
		dok_d = dok_q;
		port_d = port_q;
		ack_d = ack_q;
		rlen_d = rlen_q;
		r0_d = r0_q;
		r1_d = r1_q;
		base_d = base_q;
		tx_data_d = tx_data_q;
		tx_valid_d = tx_valid_q;
		rate232_d = rate232_q;
		rate485_d = rate485_q;
		bak_d = bak_q;
		nv_wr_d = 1'b0;
		nv_item_d = nv_item_q;
		nv_data_d = nv_data_q;
		rs_clr = 1'b0;
		rs_en = 1'b0;
		ts_clr = 1'b0;
		ts_en = 1'b0;
		ts_din = 8'h00;
		case (st_q)
			S_LOAD:
			begin
				// restore stored settings once after reset release
				bak_d = nv_programmed ? nv_bak_code : BAK_UNPROG; // RL7 RL8
				rate232_d = nv_programmed ? nv_rate_232 : RATE_RST;
				rate485_d = nv_programmed ? nv_rate_485 : RATE_RST;
				st_d = S_SYNC;
			end
			S_SYNC:
			begin
				if (rx_valid && rx_data == FRM_CMD) // RL1
				begin
					rs_clr = 1'b1;
					rs_en = 1'b1;
					idx_d = 8'd1;
					port_d = rx_from_485;
					st_d = S_HDR;
				end
			end
			S_HDR:
			begin
				if (rx_valid)
				begin
					rs_en = 1'b1;
					idx_d = idx_q + 8'd1;
					case (idx_q)
						8'd1: addr_d = rx_data;
						8'd2: cmd_d[23:16] = rx_data;
						8'd3: cmd_d[15:8] = rx_data;
						8'd4: cmd_d[7:0] = rx_data;
						default:
						begin
							len_d = rx_data;
							st_d = S_HCHK;
						end
					endcase
				end
			end
			S_HCHK:
			begin
				if (rx_valid)
				begin
					hok_d = (rx_data == rs_chk); // RL19
					dok_d = 1'b1;
					rs_clr = 1'b1;
					idx_d = 8'd0;
					st_d = (len_q == 8'd0) ? S_EXEC : S_DATA;
				end
			end
			S_DATA:
			begin
				if (rx_valid)
				begin
					rs_en = 1'b1;
					if (idx_q == 8'd0)
						d0_d = rx_data;
					if (idx_q == 8'd1)
						d1_d = rx_data;
					idx_d = idx_q + 8'd1;
					if (idx_q == len_q - 8'd1)
						st_d = S_DCHK;
				end
			end
			S_DCHK:
			begin
				if (rx_valid)
				begin
					dok_d = (rx_data == rs_chk); // RL19
					st_d = S_EXEC;
				end
			end
			S_EXEC:
			begin
				// anything not recognised below is refused
				ack_d = FRM_NAK;
				rlen_d = 8'd0;
				pend_d = P_NONE;
				if (ok && cmd_q == CMD_PORT_RATE)
				begin
					if (len_q == 8'd2 && d0_code && d1_code) // RL2
					begin
						ack_d = FRM_ACK;
						rlen_d = 8'd2;
						r0_d = d0_q;
						r1_d = d1_q;
						pend_d = P_RATE; // RL20
					end
					else if (len_q == 8'd1 && d0_code) // RL4
					begin
						ack_d = FRM_ACK;
						rlen_d = 8'd2;
						r0_d = d0_q;
						r1_d = (d0_q == CODE_HIGH) ? rate485_q : rate232_q;
					end
				end
				if (ok && cmd_q == CMD_BCAST_REPLY)
				begin
					if (len_q == 8'd1 && d0_code) // RL5
					begin
						ack_d = FRM_ACK;
						rlen_d = 8'd1;
						r0_d = d0_q;
						pend_d = P_BAK; // RL6
					end
					else if (len_q == 8'd0) // RL9
					begin
						ack_d = FRM_ACK;
						rlen_d = 8'd1;
						r0_d = bak_q;
					end
				end
				if (ok && cmd_q == CMD_PKT_FETCH && dl_ok &&
					(len_q == 8'd1 || len_q == 8'd2)) // RL10
				begin
					ack_d = FRM_ACK;
					// payload capped so data stays within 32 bytes
					rlen_d = 8'(PKT_OVERHEAD + ((dl_rem > PKT_PAYLOAD) ?
						PKT_PAYLOAD : dl_rem)); // RL12
					r0_d = d0_q; // RL11
					r1_d = SEP_HYPHEN; // RL11
					base_d = {dl_tbl, dl_off[TBL_AW-1:0]};
				end
				if (ok && cmd_q == CMD_PKT_COUNT && len_q == 8'd0 &&
					act_ok && act_size != 13'd0) // RL14 RL17
				begin
					ack_d = FRM_ACK;
					rlen_d = 8'd2;
					r0_d = act_cnt; // RL14
					r1_d = {6'h00, act_tbl}; // RL15
				end
				idx_d = 8'd0;
				ts_clr = 1'b1;
				// quiet broadcast on the RS485 side still executes
				if (port_q && addr_q == FRM_BCAST_ADDR && bak_q == CODE_LOW)
					st_d = S_APPLY;
				else
					st_d = S_TX;
			end
			S_TX:
			begin
				if (!tx_valid_q || tx_ready)
				begin
					if (idx_q == tot)
					begin
						tx_valid_d = 1'b0;
						st_d = S_APPLY;
					end
					else
					begin
						tx_valid_d = 1'b1;
						idx_d = idx_q + 8'd1;
						ts_en = 1'b1;
						case (idx_q)
							8'd0: ts_din = ack_q; // RL1
							8'd1: ts_din = addr_q; // RL1
							8'd2: ts_din = cmd_q[23:16];
							8'd3: ts_din = cmd_q[15:8];
							8'd4: ts_din = cmd_q[7:0];
							8'd5: ts_din = rlen_q;
							default:
							begin
								if (dj == 8'd0)
									ts_din = r0_q;
								else if (dj == 8'd1)
									ts_din = r1_q;
								else
									ts_din = mem_q[rd_addr]; // RL11
							end
						endcase
						tx_data_d = ts_din;
						// check bytes restart the sum for the data part
						if (idx_q == 8'd6 || idx_q == tot - 8'd1)
						begin
							tx_data_d = ts_chk;
							ts_en = 1'b0;
							ts_clr = 1'b1;
						end
					end
				end
			end
			S_APPLY:
			begin
				// last reply byte already taken, so old rate saw it out
				if (pend_q == P_RATE) // RL20
				begin
					if (r0_q == CODE_HIGH)
						rate485_d = r1_q;
					else
						rate232_d = r1_q;
					nv_wr_d = 1'b1;
					nv_item_d = (r0_q == CODE_HIGH) ? NV_RATE_485 : NV_RATE_232;
					nv_data_d = r1_q;
				end
				if (pend_q == P_BAK) // RL6
				begin
					bak_d = r0_q;
					nv_wr_d = 1'b1; // RL7
					nv_item_d = NV_BAK;
					nv_data_d = r0_q;
				end
				pend_d = P_NONE;
				st_d = S_SYNC;
			end
			default: st_d = S_SYNC;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= S_LOAD;
			pend_q <= P_NONE;
			idx_q <= 8'h00;
			addr_q <= 8'h00;
			len_q <= 8'h00;
			cmd_q <= 24'h000000;
			d0_q <= 8'h00;
			d1_q <= 8'h00;
			hok_q <= 1'b0;
			dok_q <= 1'b0;
			port_q <= 1'b0;
			ack_q <= FRM_NAK;
			rlen_q <= 8'h00;
			r0_q <= 8'h00;
			r1_q <= 8'h00;
			base_q <= '0;
			tx_data_q <= 8'h00;
			tx_valid_q <= 1'b0;
			rate232_q <= RATE_RST;
			rate485_q <= RATE_RST;
			bak_q <= BAK_UNPROG;
			nv_wr_q <= 1'b0;
			nv_item_q <= NV_RATE_232;
			nv_data_q <= 8'h00;
		end
		else
		begin
			st_q <= st_d;
			pend_q <= pend_d;
			idx_q <= idx_d;
			addr_q <= addr_d;
			len_q <= len_d;
			cmd_q <= cmd_d;
			d0_q <= d0_d;
			d1_q <= d1_d;
			hok_q <= hok_d;
			dok_q <= dok_d;
			port_q <= port_d;
			ack_q <= ack_d;
			rlen_q <= rlen_d;
			r0_q <= r0_d;
			r1_q <= r1_d;
			base_q <= base_d;
			tx_data_q <= tx_data_d;
			tx_valid_q <= tx_valid_d;
			rate232_q <= rate232_d;
			rate485_q <= rate485_d;
			bak_q <= bak_d;
			nv_wr_q <= nv_wr_d;
			nv_item_q <= nv_item_d;
			nv_data_q <= nv_data_d;
		end
	end

	assign tx_data = tx_data_q;
	assign tx_valid = tx_valid_q;
	assign rate_232 = rate232_q;
	assign rate_485 = rate485_q;
	assign bak_on = bak_q[0];
	assign nv_wr = nv_wr_q;
	assign nv_wr_item = nv_item_q;
	assign nv_wr_data = nv_data_q;
endmodule
`default_nettype wire

// File: core/scd_pkg.sv
// constants and types shared by the serial configuration interpreter
`default_nettype none
package scd_pkg;
	// frame lead bytes, broadcast address and hyphen separator
	localparam logic [7:0] FRM_CMD = 8'h07;
	localparam logic [7:0] FRM_ACK = 8'h06;
	localparam logic [7:0] FRM_NAK = 8'h15;
	localparam logic [7:0] FRM_BCAST_ADDR = 8'hFF;
	localparam logic [7:0] SEP_HYPHEN = 8'h2D;
	// command letters
	localparam logic [23:0] CMD_PORT_RATE = 24'h434252;
	localparam logic [23:0] CMD_BCAST_REPLY = 24'h42414B;
	localparam logic [23:0] CMD_PKT_FETCH = 24'h444C4E;
	localparam logic [23:0] CMD_PKT_COUNT = 24'h444C3F;
	// byte codes
	localparam logic [7:0] CODE_LOW = 8'h00;
	localparam logic [7:0] CODE_HIGH = 8'hFF;
	localparam logic [7:0] RATE_RST = 8'h00;
	localparam logic [7:0] BAK_UNPROG = 8'hFF;
	// table geometry
	localparam int TBL_NUM = 4;
	localparam int TBL_AW = 10;
	localparam int MEM_AW = 12;
	localparam int SIZE_W = 11;
	localparam logic [12:0] PKT_MAX_DATA = 13'd32;
	localparam logic [12:0] PKT_OVERHEAD = 13'd2;
	localparam logic [12:0] PKT_PAYLOAD = PKT_MAX_DATA - PKT_OVERHEAD;
	// calibration mode codes
	localparam logic [2:0] CAL_NONE = 3'h0;
	localparam logic [2:0] CAL_HDMI = 3'h4;
	// apb register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TBL_PTR = 8'h04;
	localparam logic [7:0] REG_TBL_DATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_SIZE0 = 8'h10;
	// nonvolatile write item codes
	localparam logic [1:0] NV_RATE_232 = 2'h0;
	localparam logic [1:0] NV_RATE_485 = 2'h1;
	localparam logic [1:0] NV_BAK = 2'h2;
	typedef enum logic [3:0]
	{
		S_LOAD, S_SYNC, S_HDR, S_HCHK, S_DATA, S_DCHK, S_EXEC, S_TX, S_APPLY
	} scd_state_t;
	typedef enum logic [1:0] {P_NONE, P_RATE, P_BAK} scd_pend_t;
endpackage
`default_nettype wire

// File: core/scd_chk_acc.sv
// running byte sum that yields the frame check byte
`timescale 1ns/10ps
`default_nettype none
module scd_chk_acc
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic en,
	input wire logic [7:0] din,
	output logic [7:0] chk
);
	logic [7:0] acc_q;
	logic [7:0] acc_d;

	// clear together with enable starts a fresh sum at din
	always_comb
	begin
		acc_d = clr ? 8'h00 : acc_q;
		if (en)
			acc_d = acc_d + din;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			acc_q <= 8'h00;
		else
			acc_q <= acc_d;
	end

	// check byte brings the byte sum of the covered bytes to all ones
	assign chk = ~acc_q;
endmodule
`default_nettype wire

// File: bench/scd_serial_cfg_props.sv
// port checker for the serial configuration interpreter
`timescale 1ns/10ps
`default_nettype none
module scd_serial_cfg_props
	import scd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic nv_wr,
	input wire logic [7:0] rate_232,
	input wire logic [7:0] rate_485,
	input wire logic bak_on
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////
	// every reply opens with an acknowledge or a refusal byte
	AST_LEAD_BYTE: assert property ($rose(tx_valid) |->
		tx_data == FRM_ACK || tx_data == FRM_NAK)
		else $error("reply lead byte wrong");
	// a stalled byte must not move
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data))
		else $error("reply byte dropped or changed");
	// settings only move once the line is quiet again
	AST_BAK_AFTER: assert property ($changed(bak_on) |-> !tx_valid)
		else $error("broadcast reply changed mid answer");
	AST_RATE_AFTER: assert property (
		$changed(rate_232) || $changed(rate_485) |-> !tx_valid)
		else $error("rate changed mid answer");
	AST_NV_AFTER: assert property (nv_wr |-> !tx_valid)
		else $error("store written mid answer");
	AST_NV_PULSE: assert property (nv_wr |=> !nv_wr)
		else $error("store strobe too long");
	// one wait state, then a single ready cycle
	AST_PREADY_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("ready late");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("ready held");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready && penable)
		else $error("error outside access");
	COV_STORE: cover property (nv_wr);
	COV_NAK: cover property (tx_valid && tx_data == FRM_NAK);
	COV_SLVERR: cover property (pslverr);
endmodule
bind scd_serial_cfg scd_serial_cfg_props u_props
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .nv_wr(nv_wr),
	.rate_232(rate_232), .rate_485(rate_485), .bak_on(bak_on)
);
`default_nettype wire

// File: bench/scd_host_model.sv
// host model: frames commands onto the byte link, gathers replies
`timescale 1ns/10ps
`default_nettype none
module scd_host_model
	import scd_pkg::*;
(
	input wire logic pclk,
	input wire logic slow,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	logic [7:0] d [0:31];
	logic [7:0] f [0:40];
	logic [7:0] g [0:40];
	int fl;
	int gl;
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
		gl = 0;
	end
	////////////////////////////////////////////////////////////////////
	// header check spans bytes 0..5; data check only when data exist
	task automatic mk(input logic [7:0] ld, input logic [23:0] c, input int n);
		logic [7:0] s;
		{f[0], f[1], f[2], f[3], f[4], f[5]} = {ld, FRM_BCAST_ADDR, c, 8'(n)};
		s = 8'h00;
		for (int i = 0; i < 6; i++)
			s += f[i];
		f[6] = ~s;
		s = 8'h00;
		for (int i = 0; i < n; i++)
		begin
			f[7 + i] = d[i];
			s += d[i];
		end
		f[7 + n] = ~s;
		fl = (n > 0) ? 8 + n : 7;
	endtask
	// one byte a cycle; the released line shows the inverse, not a stale byte
	task automatic send();
		for (int i = 0; i < fl; i++)
		begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_data <= f[i];
		end
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_data <= ~f[fl - 1];
	endtask
	// replies taken where ready meets valid; slow mode stalls every other cycle
	always @(posedge pclk)
	begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready && gl < 41)
		begin
			g[gl] <= tx_data;
			gl <= gl + 1;
		end
	end
endmodule
`default_nettype wire

// File: bench/scd_serial_cfg_tb.sv
// self-checking bench for the serial configuration interpreter
`timescale 1ns/10ps
`default_nettype none
module scd_serial_cfg_tb
	import scd_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, rx_data, tx_data, nv_rate_232, nv_rate_485;
	logic [31:0] pwdata, prdata, rd;
	logic rx_valid, tx_valid, tx_ready, slow, nv_programmed, nv_wr, bak_on;
	logic from_485;
	logic [9:0] nv_last;
	logic [1:0] nv_wr_item;
	logic [7:0] nv_wr_data, rate_232, rate_485;
	int num_errors, n_tests, k;
	scd_serial_cfg dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_from_485(from_485), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready),
		.nv_programmed(nv_programmed), .nv_rate_232(nv_rate_232),
		.nv_rate_485(nv_rate_485), .nv_bak_code(8'h00), .nv_wr(nv_wr),
		.nv_wr_item(nv_wr_item), .nv_wr_data(nv_wr_data),
		.rate_232(rate_232), .rate_485(rate_485), .bak_on(bak_on)
	);
	scd_host_model host
	(
		.pclk(pclk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
	);
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// last store request, for the nonvolatile checks
	always @(posedge pclk)
	begin
		if (nv_wr)
			nv_last <= {nv_wr_item, nv_wr_data};
	end
	////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rst();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
	// one apb transfer, held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed; the watchdog ends a hung wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic apb_r(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		cmp(rd, e);
		cmp({31'h0, err}, {31'h0, ee});
	endtask
	task automatic xfer(input logic [23:0] c, input int n, input logic bad);
		host.mk(FRM_CMD, c, n);
		host.f[6] = host.f[6] ^ {7'h00, bad};
		host.gl = 0;
		host.send();
	endtask
	// whole reply compared with the frame the host would expect
	task automatic reply(input logic [7:0] ld, input logic [23:0] c, input int m);
		host.mk(ld, c, m);
		for (int i = 0; i < 3000 && host.gl < host.fl; i++)
			@(posedge pclk);
		repeat (4) @(posedge pclk);
		cmp(32'(host.gl), 32'(host.fl));
		for (int i = 0; i < host.fl; i++)
			cmp({24'h0, host.g[i]}, {24'h0, host.f[i]});
	endtask
	task automatic pkt(input int p, input int m);
		host.d[0] = 8'(p);
		host.d[1] = SEP_HYPHEN;
		for (int i = 0; i < m - 2; i++)
			host.d[2 + i] = 8'(32 + p * 30 + i);
	endtask
	initial
	begin
		#500000;
		num_errors++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////
	initial
	begin
		{presetn, psel, penable, pwrite, slow, nv_programmed, from_485} = 7'h00;
		{paddr, nv_rate_232, nv_rate_485, pwdata} = 56'h0;
		rst();
		apb_r(REG_STATUS, 32'h00FF0000, 1'b0);
		cmp({31'h0, bak_on}, 32'h1);
		apb_r(8'h40, 32'h0, 1'b1);
		$display("test reset values done");
		// table 1 gets 40 bytes: one full packet and one of 10
		apb(1'b1, REG_TBL_PTR, 32'd1024);
		for (k = 0; k < 40; k++)
			apb(1'b1, REG_TBL_DATA, 32'(32 + k));
		apb(1'b1, REG_SIZE0 + 8'h04, 32'd40);
		for (k = 0; k < 5; k++)
		begin
			apb(1'b1, REG_CTRL, 32'(k));
			xfer(CMD_PKT_COUNT, 0, 1'b0);
			host.d[0] = 8'h02;
			host.d[1] = 8'h01;
			if (k == 2)
				reply(FRM_ACK, CMD_PKT_COUNT, 2);
			else
				reply(FRM_NAK, CMD_PKT_COUNT, 0);
		end
		apb(1'b1, REG_CTRL, 32'h2);
		host.d[0] = 8'h01;
		xfer(CMD_PKT_FETCH, 1, 1'b0);
		pkt(1, 12);
		reply(FRM_ACK, CMD_PKT_FETCH, 12);
		apb(1'b1, REG_CTRL, 32'h0);
		host.d[0] = 8'h00;
		host.d[1] = 8'h01;
		xfer(CMD_PKT_FETCH, 2, 1'b0);
		pkt(0, 32);
		reply(FRM_ACK, CMD_PKT_FETCH, 32);
		$display("test table download done");
		// both ports to the fast code while the reader stalls
		slow <= 1'b1;
		for (k = 0; k < 2; k++)
		begin
			host.d[0] = 8'(0 - k);
			host.d[1] = CODE_HIGH;
			xfer(CMD_PORT_RATE, 2, 1'b0);
			reply(FRM_ACK, CMD_PORT_RATE, 2);
			xfer(CMD_PORT_RATE, 1, 1'b0);
			reply(FRM_ACK, CMD_PORT_RATE, 2);
		end
		cmp({16'h0, rate_485, rate_232}, 32'hFFFF);
		cmp({22'h0, nv_last}, {22'h0, NV_RATE_485, CODE_HIGH});
		host.d[0] = CODE_LOW;
		host.d[1] = CODE_LOW;
		xfer(CMD_PORT_RATE, 2, 1'b1);
		reply(FRM_NAK, CMD_PORT_RATE, 0);
		cmp({24'h0, rate_232}, 32'hFF);
		slow <= 1'b0;
		$display("test port rates done");
		for (k = 0; k < 2; k++)
		begin
			host.d[0] = 8'(k - 1);
			xfer(CMD_BCAST_REPLY, 1, 1'b0);
			reply(FRM_ACK, CMD_BCAST_REPLY, 1);
			cmp({31'h0, bak_on}, 32'(1 - k));
			xfer(CMD_BCAST_REPLY, 0, 1'b0);
			reply(FRM_ACK, CMD_BCAST_REPLY, 1);
		end
		cmp({22'h0, nv_last}, {22'h0, NV_BAK, CODE_LOW});
		// quiet broadcast from the RS485 side: no answer, still applied
		host.d[0] = CODE_HIGH;
		from_485 <= 1'b1;
		xfer(CMD_BCAST_REPLY, 1, 1'b0);
		repeat (40) @(posedge pclk);
		cmp(32'(host.gl), 32'h0);
		cmp({31'h0, bak_on}, 32'h1);
		cmp({22'h0, nv_last}, {22'h0, NV_BAK, CODE_HIGH});
		xfer(CMD_BCAST_REPLY, 0, 1'b0);
		reply(FRM_ACK, CMD_BCAST_REPLY, 1);
		from_485 <= 1'b0;
		$display("test broadcast reply done");
		// a programmed store brings its values back after reset
		nv_programmed <= 1'b1;
		nv_rate_232 <= CODE_HIGH;
		rst();
		apb_r(REG_STATUS, 32'h000000FF, 1'b0);
		cmp({31'h0, bak_on}, 32'h0);
		$display("test restore done");
		stop_test();
	end
endmodule
`default_nettype wire
